//--- logic/ppm_pkg.sv
package ppm_pkg;

   // ----------------------------------------------------------------
   // Pin bank geometry
   // ----------------------------------------------------------------
   localparam int          PIN_LO    = 3;
   localparam int          PIN_HI    = 31;
   localparam int          PIN_IDX_W = 5;
   localparam int          NUM_PORTS = 6;
   localparam int          WR_CYCLES = 2;
   localparam logic        EXT_RST_N_RESET = 1'b1;
   localparam logic        LOAD_RESET      = 1'b1;

   // ----------------------------------------------------------------
   // Strap levels, write sources, pin functions
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      LVL_PD_200K, LVL_PU_200K, LVL_PD_10K, LVL_PU_10K, LVL_PD_10R, LVL_PU_10R
   } ppm_strap_t;

   typedef enum logic [1:0] {
      SRC_TWOWIRE_CFG, SRC_OTP, SRC_TWOWIRE_RUN, SRC_USB_RUN
   } ppm_src_t;

   typedef enum logic [4:0] {
      FN_NONE,
      FN_AUDIO_DIN, FN_AUDIO_DOUT, FN_AUDIO_SCK, FN_AUDIO_WS, FN_AUDIO_MCLK,
      FN_P3_SS_PWR, FN_P4_SS_PWR, FN_P5_SS_PWR,
      FN_P1_PWR, FN_P2_PWR, FN_P3_PWR, FN_P4_PWR, FN_P5_PWR, FN_P6_PWR,
      FN_BRIDGE_CLK, FN_BRIDGE_DAT, FN_MICROPHONE_DETECT,
      FN_FLASH_CE_N, FN_FLASH_CLK, FN_FLASH_IO0, FN_FLASH_IO1, FN_FLASH_IO2, FN_FLASH_IO3,
      FN_TARGET_CLK, FN_TARGET_DAT, FN_BUS_DET
   } ppm_func_t;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       out;
      logic       oe_n;
      logic       pu;
      logic       pd;
   } ppm_pad_t;

   typedef struct packed {
      logic       audio_data_out;
      logic       audio_sck;
      logic       audio_word_select;
      logic       audio_mclk;
      logic       bridge_clk_oe_n;
      logic       bridge_dat_oe_n;
      logic       target_clk_oe_n;
      logic       target_dat_oe_n;
      logic       flash_ce_n;
      logic       flash_clk;
      logic [3:0] flash_io_out;
      logic [3:0] flash_io_oe_n;
   } ppm_fn_out_t;

   typedef struct packed {
      logic       audio_data_in;
      logic       microphone_present;
      logic       upstream_bus_power;
      logic       bridge_twowire_clock;
      logic       bridge_twowire_data;
      logic       target_twowire_clock;
      logic       target_twowire_data;
      logic [3:0] flash_io_in;
      logic [5:0] port_overcurrent_n;
      logic [2:0] ss_overcurrent_n;
   } ppm_fn_in_t;

   localparam ppm_pad_t PAD_IDLE = '{out: 1'b0, oe_n: 1'b1, pu: 1'b0, pd: 1'b0};

   // Default pin map of the only supported strap configuration, pin 3 first
   localparam ppm_func_t CFG3_MAP [PIN_LO:PIN_HI] = '{
      FN_AUDIO_DIN, FN_AUDIO_DOUT, FN_AUDIO_SCK, FN_AUDIO_WS, FN_AUDIO_MCLK,
      FN_NONE, FN_NONE,
      FN_P3_SS_PWR, FN_P4_SS_PWR, FN_P5_SS_PWR,
      FN_P5_PWR, FN_P4_PWR, FN_P3_PWR, FN_P2_PWR, FN_P1_PWR,
      FN_BRIDGE_CLK, FN_MICROPHONE_DETECT,
      FN_FLASH_CE_N, FN_FLASH_CLK, FN_FLASH_IO0, FN_FLASH_IO1, FN_FLASH_IO2, FN_FLASH_IO3,
      FN_TARGET_CLK, FN_TARGET_DAT, FN_P6_PWR,
      FN_NONE, FN_BUS_DET, FN_BRIDGE_DAT
   };

endpackage

//--- logic/ppm_pin_mux.sv
`timescale 1ns/10ps
// Summary of operation
// - A bank of 29 function pins, 3 to 31, each routed by the mux.
// - Exactly one default map, chosen by decoding select straps 1 and 2.
// - Configuration 3 when strap 2 is 200k pull-down and strap 1 10k pull-down.
// - Configurations 1 and 2 do not exist; configuration 3 map is the only default.
// - Pins 3 to 7 carry audio data in, data out, clock, word select, master clock.
// - Pins 8,9 open; 10-12 SS power 3-5; 13-17 power 5-1; 28 power 6.
// - Pin 29 has no default function unless software assigns one.
// - Pins 18 and 31 carry bridging two-wire controller clock and data.
// - Pins 26 and 27 carry target two-wire controller clock and data.
// - Audio word select is driven as an output when routed.
// - Audio serial clock driven as output continuously; data in is an input.
// - Microphone detect on pin 19: one means plugged, zero means none.
// - Pins 20-25 carry flash enable, clock, four data; pin 30 bus detect.
// - Any pin's default function can be replaced by a mux register write.
// - Overrides accepted from two-wire configuration stage and OTP before attach.
// - After attach, writes accepted from target two-wire port and USB commands.
// - Straps latched after power-on reset and on external reset rising edge.
// - Power control pin: pulled-up input while enabled, driven low when disabled.
module ppm_pin_mux (
   input  logic                               mclk,
   input  logic                               srst,
   input  logic                               ext_reset_n,
   input  ppm_pkg::ppm_strap_t                select_strap1,
   input  ppm_pkg::ppm_strap_t                select_strap2,
   input  ppm_pkg::ppm_strap_t                spare_select_strap,
   input  logic                               hub_attached,
   input  logic                               wr_valid,
   input  ppm_pkg::ppm_src_t                  wr_src,
   input  logic [ppm_pkg::PIN_IDX_W-1:0]      wr_pin,
   input  ppm_pkg::ppm_func_t                 wr_func,
   output logic                               wr_accept,
   output logic                               wr_reject,
   input  logic [ppm_pkg::NUM_PORTS-1:0]      port_enable,
   input  ppm_pkg::ppm_fn_out_t               fn_out,
   output ppm_pkg::ppm_fn_in_t                fn_in,
   output logic                               cfg3_active,
   output logic                               strap_reserved,
   output logic                               spare_strap_ok,
   input  logic [ppm_pkg::PIN_HI:ppm_pkg::PIN_LO] prog_function_pins_in,
   output logic [ppm_pkg::PIN_HI:ppm_pkg::PIN_LO] prog_function_pins_out,
   output logic [ppm_pkg::PIN_HI:ppm_pkg::PIN_LO] prog_function_pins_oe_n,
   output logic [ppm_pkg::PIN_HI:ppm_pkg::PIN_LO] prog_function_pins_pu,
   output logic [ppm_pkg::PIN_HI:ppm_pkg::PIN_LO] prog_function_pins_pd
);

   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   // Write index must reach the top pin; the pad helpers decode six ports only
   if (ppm_pkg::PIN_HI >= (1 << ppm_pkg::PIN_IDX_W)) begin : g_idx_chk
      $error("pin index too narrow for the pin bank");
   end
   if (ppm_pkg::NUM_PORTS != 6) begin : g_port_chk
      $error("power pin decode serves six ports only");
   end

   // ----------------------------------------------------------------
   // Pad drive helpers
   // ----------------------------------------------------------------
   function automatic ppm_pkg::ppm_pad_t pwr_pad(input logic en);
      ppm_pkg::ppm_pad_t d;
      // Enabled port: pad listens through its pull-up; disabled port: pad sinks the line
      d = '{out: 1'b0, oe_n: en, pu: en, pd: 1'b0};
      return d;
   endfunction

   function automatic ppm_pkg::ppm_pad_t drv_pad(input logic val);
      ppm_pkg::ppm_pad_t d;
      d = '{out: val, oe_n: 1'b0, pu: 1'b0, pd: 1'b0};
      return d;
   endfunction

   function automatic ppm_pkg::ppm_pad_t pad_drive(input ppm_pkg::ppm_func_t   f,
                                                   input ppm_pkg::ppm_fn_out_t fo,
                                                   input logic [5:0]           pen);
      ppm_pkg::ppm_pad_t d;
      d = ppm_pkg::PAD_IDLE;
      case (f)
         ppm_pkg::FN_AUDIO_DOUT: d = drv_pad(fo.audio_data_out);
         ppm_pkg::FN_AUDIO_SCK:  d = drv_pad(fo.audio_sck);
         ppm_pkg::FN_AUDIO_WS:   d = drv_pad(fo.audio_word_select);
         ppm_pkg::FN_AUDIO_MCLK: d = drv_pad(fo.audio_mclk);
         ppm_pkg::FN_P3_SS_PWR:  d = pwr_pad(pen[2]);
         ppm_pkg::FN_P4_SS_PWR:  d = pwr_pad(pen[3]);
         ppm_pkg::FN_P5_SS_PWR:  d = pwr_pad(pen[4]);
         ppm_pkg::FN_P1_PWR:     d = pwr_pad(pen[0]);
         ppm_pkg::FN_P2_PWR:     d = pwr_pad(pen[1]);
         ppm_pkg::FN_P3_PWR:     d = pwr_pad(pen[2]);
         ppm_pkg::FN_P4_PWR:     d = pwr_pad(pen[3]);
         ppm_pkg::FN_P5_PWR:     d = pwr_pad(pen[4]);
         ppm_pkg::FN_P6_PWR:     d = pwr_pad(pen[5]);
         // Open-drain lines only ever pull low; board pull-ups do the rest
         ppm_pkg::FN_BRIDGE_CLK: d.oe_n = fo.bridge_clk_oe_n;
         ppm_pkg::FN_BRIDGE_DAT: d.oe_n = fo.bridge_dat_oe_n;
         ppm_pkg::FN_TARGET_CLK: d.oe_n = fo.target_clk_oe_n;
         ppm_pkg::FN_TARGET_DAT: d.oe_n = fo.target_dat_oe_n;
         ppm_pkg::FN_FLASH_CE_N: d = drv_pad(fo.flash_ce_n);
         ppm_pkg::FN_FLASH_CLK:  d = drv_pad(fo.flash_clk);
         ppm_pkg::FN_FLASH_IO0:  d = '{out: fo.flash_io_out[0], oe_n: fo.flash_io_oe_n[0], pu: 1'b0, pd: 1'b0};
         ppm_pkg::FN_FLASH_IO1:  d = '{out: fo.flash_io_out[1], oe_n: fo.flash_io_oe_n[1], pu: 1'b0, pd: 1'b0};
         ppm_pkg::FN_FLASH_IO2:  d = '{out: fo.flash_io_out[2], oe_n: fo.flash_io_oe_n[2], pu: 1'b0, pd: 1'b0};
         ppm_pkg::FN_FLASH_IO3:  d = '{out: fo.flash_io_out[3], oe_n: fo.flash_io_oe_n[3], pu: 1'b0, pd: 1'b0};
         ppm_pkg::FN_AUDIO_DIN, ppm_pkg::FN_MICROPHONE_DETECT, ppm_pkg::FN_BUS_DET: d = ppm_pkg::PAD_IDLE;
         // Unrouted or illegal code: driver off, weak pull-down
         default:                d.pd = 1'b1;
      endcase
      return d;
   endfunction

   // ----------------------------------------------------------------
   // Strap capture
   // ----------------------------------------------------------------
   logic                load_ff;
   logic                ext_rst_n_q_ff;
   logic                cfg3_ff;
   logic                reserved_ff;
   logic                spare_ok_ff;
   wire                 ext_rise  = ext_reset_n & ~ext_rst_n_q_ff;
   wire                 load_evt  = load_ff | ext_rise;
   wire                 cfg3_now  = (select_strap2 == ppm_pkg::LVL_PD_200K) &&
                                    (select_strap1 == ppm_pkg::LVL_PD_10K);
   wire                 spare_now = (spare_select_strap == ppm_pkg::LVL_PD_200K);

   // Level captured one edge after reset release, never inside the reset branch
   always_ff @(posedge mclk) begin
      if (srst) begin
         load_ff        <= ppm_pkg::LOAD_RESET;
         ext_rst_n_q_ff <= ppm_pkg::EXT_RST_N_RESET;
         cfg3_ff        <= 1'b0;
         reserved_ff    <= 1'b0;
         spare_ok_ff    <= 1'b0;
      end else begin
         load_ff        <= 1'b0;
         ext_rst_n_q_ff <= ext_reset_n;
         if (load_evt) begin
            cfg3_ff     <= cfg3_now;
            reserved_ff <= ~cfg3_now;
            spare_ok_ff <= spare_now;
         end
      end
   end

   assign cfg3_active    = cfg3_ff;
   assign strap_reserved = reserved_ff;
   assign spare_strap_ok = spare_ok_ff;

   // ----------------------------------------------------------------
   // Override acceptance
   // ----------------------------------------------------------------
   wire                 pin_in_range = (wr_pin >= ppm_pkg::PIN_IDX_W'(ppm_pkg::PIN_LO)) &&
                                       (wr_pin <= ppm_pkg::PIN_IDX_W'(ppm_pkg::PIN_HI));
   wire                 src_pre  = (wr_src == ppm_pkg::SRC_TWOWIRE_CFG) || (wr_src == ppm_pkg::SRC_OTP);
   wire                 src_ok   = src_pre ? ~hub_attached : hub_attached;
   // A strap reload outranks a write in the same cycle; the write is refused
   assign wr_accept = wr_valid & pin_in_range & src_ok & ~load_evt;
   assign wr_reject = wr_valid & ~wr_accept;

   // ----------------------------------------------------------------
   // Function selection per pin
   // ----------------------------------------------------------------
   ppm_pkg::ppm_func_t  func_ff  [ppm_pkg::PIN_HI:ppm_pkg::PIN_LO];
   ppm_pkg::ppm_func_t  nxt_func [ppm_pkg::PIN_HI:ppm_pkg::PIN_LO];
   ppm_pkg::ppm_pad_t   pad_ff   [ppm_pkg::PIN_HI:ppm_pkg::PIN_LO];
   ppm_pkg::ppm_pad_t   nxt_pad  [ppm_pkg::PIN_HI:ppm_pkg::PIN_LO];
   logic [ppm_pkg::PIN_HI:ppm_pkg::PIN_LO] func_none_vec;

   always_comb begin
      for (int p = ppm_pkg::PIN_LO; p <= ppm_pkg::PIN_HI; p++) begin
         if (load_evt) begin
            // Only configuration 3 exists; any other strap pair leaves pins unrouted
            nxt_func[p] = cfg3_now ? ppm_pkg::CFG3_MAP[p] : ppm_pkg::FN_NONE;
         end else if (wr_accept && (wr_pin == ppm_pkg::PIN_IDX_W'(p))) begin
            nxt_func[p] = wr_func;
         end else begin
            nxt_func[p] = func_ff[p];
         end
         nxt_pad[p]       = pad_drive(func_ff[p], fn_out, port_enable);
         func_none_vec[p] = (func_ff[p] == ppm_pkg::FN_NONE);
      end
   end

   // Registered pads: a change on one pin cannot disturb its neighbours
   always_ff @(posedge mclk) begin
      for (int p = ppm_pkg::PIN_LO; p <= ppm_pkg::PIN_HI; p++) begin
         if (srst) begin
            func_ff[p] <= ppm_pkg::FN_NONE;
            pad_ff[p]  <= ppm_pkg::PAD_IDLE;
         end else begin
            func_ff[p] <= nxt_func[p];
            pad_ff[p]  <= nxt_pad[p];
         end
      end
   end

   always_comb begin
      for (int p = ppm_pkg::PIN_LO; p <= ppm_pkg::PIN_HI; p++) begin
         prog_function_pins_out[p]  = pad_ff[p].out;
         prog_function_pins_oe_n[p] = pad_ff[p].oe_n;
         prog_function_pins_pu[p]   = pad_ff[p].pu;
         prog_function_pins_pd[p]   = pad_ff[p].pd;
      end
   end

   // ----------------------------------------------------------------
   // Input gathering
   // ----------------------------------------------------------------
   ppm_pkg::ppm_fn_in_t fn_in_ff;
   ppm_pkg::ppm_fn_in_t nxt_fn_in;

   // Unrouted inputs read idle: two-wire lines and overcurrent flags high
   always_comb begin
      nxt_fn_in = '0;
      nxt_fn_in.bridge_twowire_clock = 1'b1;
      nxt_fn_in.bridge_twowire_data  = 1'b1;
      nxt_fn_in.target_twowire_clock = 1'b1;
      nxt_fn_in.target_twowire_data  = 1'b1;
      nxt_fn_in.port_overcurrent_n   = '1;
      nxt_fn_in.ss_overcurrent_n     = '1;
      for (int p = ppm_pkg::PIN_LO; p <= ppm_pkg::PIN_HI; p++) begin
         case (func_ff[p])
            ppm_pkg::FN_AUDIO_DIN:  nxt_fn_in.audio_data_in        = prog_function_pins_in[p];
            ppm_pkg::FN_MICROPHONE_DETECT:    nxt_fn_in.microphone_present   = prog_function_pins_in[p];
            ppm_pkg::FN_BUS_DET:    nxt_fn_in.upstream_bus_power   = prog_function_pins_in[p];
            ppm_pkg::FN_BRIDGE_CLK: nxt_fn_in.bridge_twowire_clock = prog_function_pins_in[p];
            ppm_pkg::FN_BRIDGE_DAT: nxt_fn_in.bridge_twowire_data  = prog_function_pins_in[p];
            ppm_pkg::FN_TARGET_CLK: nxt_fn_in.target_twowire_clock = prog_function_pins_in[p];
            ppm_pkg::FN_TARGET_DAT: nxt_fn_in.target_twowire_data  = prog_function_pins_in[p];
            ppm_pkg::FN_FLASH_IO0:  nxt_fn_in.flash_io_in[0]       = prog_function_pins_in[p];
            ppm_pkg::FN_FLASH_IO1:  nxt_fn_in.flash_io_in[1]       = prog_function_pins_in[p];
            ppm_pkg::FN_FLASH_IO2:  nxt_fn_in.flash_io_in[2]       = prog_function_pins_in[p];
            ppm_pkg::FN_FLASH_IO3:  nxt_fn_in.flash_io_in[3]       = prog_function_pins_in[p];
            ppm_pkg::FN_P1_PWR:     nxt_fn_in.port_overcurrent_n[0] = prog_function_pins_in[p];
            ppm_pkg::FN_P2_PWR:     nxt_fn_in.port_overcurrent_n[1] = prog_function_pins_in[p];
            ppm_pkg::FN_P3_PWR:     nxt_fn_in.port_overcurrent_n[2] = prog_function_pins_in[p];
            ppm_pkg::FN_P4_PWR:     nxt_fn_in.port_overcurrent_n[3] = prog_function_pins_in[p];
            ppm_pkg::FN_P5_PWR:     nxt_fn_in.port_overcurrent_n[4] = prog_function_pins_in[p];
            ppm_pkg::FN_P6_PWR:     nxt_fn_in.port_overcurrent_n[5] = prog_function_pins_in[p];
            ppm_pkg::FN_P3_SS_PWR:  nxt_fn_in.ss_overcurrent_n[0]   = prog_function_pins_in[p];
            ppm_pkg::FN_P4_SS_PWR:  nxt_fn_in.ss_overcurrent_n[1]   = prog_function_pins_in[p];
            ppm_pkg::FN_P5_SS_PWR:  nxt_fn_in.ss_overcurrent_n[2]   = prog_function_pins_in[p];
            default:                ;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         fn_in_ff <= '0;
      end else begin
         fn_in_ff <= nxt_fn_in;
      end
   end

   assign fn_in = fn_in_ff;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking ck @(posedge mclk); endclocking
   default disable iff (srst);

   wr_takes_effect_a: assert property (wr_accept |=> func_ff[$past(wr_pin)] == $past(wr_func))
      else $error("accepted write did not update pin function");
   wr_reaches_pin_a: assert property (wr_accept && wr_func == ppm_pkg::FN_AUDIO_WS |-> ##2
      prog_function_pins_oe_n[$past(wr_pin, 2)] == 1'b0)
      else $error("rerouted pin not driving two cycles after write");
   src_gate_a: assert property (wr_valid && (wr_src == ppm_pkg::SRC_OTP) && hub_attached |-> !wr_accept)
      else $error("pre-attach source accepted after attach");
   run_src_a: assert property (wr_valid && (wr_src == ppm_pkg::SRC_USB_RUN) && !hub_attached |-> !wr_accept)
      else $error("runtime source accepted before attach");
   audio_map_a: assert property (load_evt && cfg3_now |=> func_ff[3] == ppm_pkg::FN_AUDIO_DIN &&
      func_ff[5] == ppm_pkg::FN_AUDIO_SCK && func_ff[7] == ppm_pkg::FN_AUDIO_MCLK)
      else $error("audio pins misrouted after strap load");
   power_map_a: assert property (load_evt && cfg3_now |=> func_ff[8] == ppm_pkg::FN_NONE &&
      func_ff[10] == ppm_pkg::FN_P3_SS_PWR && func_ff[17] == ppm_pkg::FN_P1_PWR &&
      func_ff[28] == ppm_pkg::FN_P6_PWR)
      else $error("power pins misrouted after strap load");
   spare_pin_a: assert property (load_evt |=> func_ff[29] == ppm_pkg::FN_NONE)
      else $error("pin 29 routed by default");
   twowire_map_a: assert property (load_evt && cfg3_now |=> func_ff[18] == ppm_pkg::FN_BRIDGE_CLK &&
      func_ff[31] == ppm_pkg::FN_BRIDGE_DAT && func_ff[26] == ppm_pkg::FN_TARGET_CLK &&
      func_ff[27] == ppm_pkg::FN_TARGET_DAT)
      else $error("two-wire pins misrouted");
   flash_map_a: assert property (load_evt && cfg3_now |=> func_ff[20] == ppm_pkg::FN_FLASH_CE_N &&
      func_ff[25] == ppm_pkg::FN_FLASH_IO3 && func_ff[30] == ppm_pkg::FN_BUS_DET)
      else $error("flash or bus detect pins misrouted");
   reserved_cfg_a: assert property (load_evt && !cfg3_now |=> &func_none_vec && strap_reserved)
      else $error("reserved straps produced a pin map");
   cfg3_decode_a: assert property (load_evt |=> cfg3_active == $past(cfg3_now))
      else $error("strap decode not latched");
   strap_latch_a: assert property ($rose(ext_reset_n) |=> strap_reserved == !$past(cfg3_now))
      else $error("straps not relatched on external reset release");
   unused_off_a: assert property ((($past(func_none_vec) & ~prog_function_pins_oe_n) == '0))
      else $error("unrouted pin driving");
   power_drive_a: assert property (func_ff[17] == ppm_pkg::FN_P1_PWR && !port_enable[0] |=>
      !prog_function_pins_oe_n[17] && !prog_function_pins_out[17])
      else $error("disabled port power pin not driven low");
   power_input_a: assert property (func_ff[28] == ppm_pkg::FN_P6_PWR && port_enable[5] |=>
      prog_function_pins_oe_n[28] && prog_function_pins_pu[28])
      else $error("enabled port power pin not pulled-up input");
   word_select_a: assert property (func_ff[6] == ppm_pkg::FN_AUDIO_WS |=> !prog_function_pins_oe_n[6] &&
      prog_function_pins_out[6] == $past(fn_out.audio_word_select))
      else $error("word select not driven");
   mic_detect_a: assert property (func_ff[19] == ppm_pkg::FN_MICROPHONE_DETECT |=>
      fn_in.microphone_present == $past(prog_function_pins_in[19]))
      else $error("microphone detect not reflected");

   // Pad direction and readback of six more routed functions; unrouted pull-down; strap hold
   din_input_a: assert property (func_ff[3] == ppm_pkg::FN_AUDIO_DIN |=> prog_function_pins_oe_n[3])
      else $error("audio data in pin driving");
   sck_drive_a: assert property (func_ff[5] == ppm_pkg::FN_AUDIO_SCK |=> !prog_function_pins_oe_n[5] &&
      prog_function_pins_out[5] == $past(fn_out.audio_sck))
      else $error("audio serial clock not driven");
   open_drain_a: assert property (func_ff[26] == ppm_pkg::FN_TARGET_CLK |=> !prog_function_pins_out[26] &&
      prog_function_pins_oe_n[26] == $past(fn_out.target_clk_oe_n))
      else $error("target clock pin not open-drain");
   flash_io_a: assert property (func_ff[22] == ppm_pkg::FN_FLASH_IO0 |=>
      prog_function_pins_oe_n[22] == $past(fn_out.flash_io_oe_n[0]))
      else $error("flash data pin direction wrong");
   unused_pull_a: assert property (!$past(srst) |-> ($past(func_none_vec) & ~prog_function_pins_pd) == '0)
      else $error("unrouted pin without weak pull-down");
   overcurrent_a: assert property (func_ff[17] == ppm_pkg::FN_P1_PWR |=>
      fn_in.port_overcurrent_n[0] == $past(prog_function_pins_in[17]))
      else $error("port power pin not read back");
   bus_detect_a: assert property (func_ff[30] == ppm_pkg::FN_BUS_DET |=>
      fn_in.upstream_bus_power == $past(prog_function_pins_in[30]))
      else $error("bus detect not reflected");
   strap_hold_a: assert property (!load_evt |=> cfg3_active == $past(cfg3_active))
      else $error("strap decode changed without a load");

   strap_reload_c: cover property (ext_rise ##1 cfg3_active);
   runtime_wr_c:   cover property (hub_attached && wr_accept && wr_src == ppm_pkg::SRC_USB_RUN);
   pre_attach_c:   cover property (!hub_attached && wr_accept && wr_src == ppm_pkg::SRC_OTP);
   reject_c:       cover property (wr_reject);
   reroute_c:      cover property (wr_accept && wr_func == ppm_pkg::FN_AUDIO_WS);

endmodule

//--- bench/ppm_board.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Board and peripherals on the function pins
// ----------------------------------------------------------------
module ppm_board (
   input  logic [31:3] pad_oe_n,
   input  logic [31:3] pad_out,
   input  logic [31:3] pad_pu,
   input  logic [31:3] pad_pd,
   input  logic [31:3] ext_en,
   input  logic [31:3] ext_val,
   output logic [31:3] pin_lvl
);
   // A floating line shows the inverse of the pad value, so it never passes as a match
   always_comb begin
      for (int p = 3; p <= 31; p++) begin
         if (!pad_oe_n[p]) pin_lvl[p] = pad_out[p];
         else if (ext_en[p]) pin_lvl[p] = ext_val[p];
         else if (pad_pu[p]) pin_lvl[p] = 1'b1;
         else if (pad_pd[p]) pin_lvl[p] = 1'b0;
         else pin_lvl[p] = ~pad_out[p];
      end
   end
endmodule

//--- bench/testbench.sv
`timescale 1ns/10ps
module testbench;
   // ----------------------------------------------------------------
   // Pad codes {oe_n, out when driven, pu, pd}, pin 31 down to pin 3
   // ----------------------------------------------------------------
   localparam logic [115:0] exp_map = 116'h089A00444444800AAAAAAA9944448;
   logic mclk = 1'b0, srst = 1'b1, ext_reset_n = 1'b1, hub_attached = 1'b0, wr_valid = 1'b0;
   logic wr_accept, wr_reject, cfg3_active, strap_reserved, spare_strap_ok;
   ppm_pkg::ppm_strap_t s1 = ppm_pkg::LVL_PD_10K, s2 = ppm_pkg::LVL_PD_200K, s3 = ppm_pkg::LVL_PD_200K;
   ppm_pkg::ppm_src_t   wr_src = ppm_pkg::SRC_OTP;
   ppm_pkg::ppm_func_t  wr_func = ppm_pkg::FN_NONE;
   ppm_pkg::ppm_fn_out_t fo = '1;
   ppm_pkg::ppm_fn_in_t fn_in;
   logic [4:0]  wr_pin = 5'h03;
   logic [5:0]  port_enable = 6'h3E;
   logic [31:3] p_in, p_out, p_oe_n, p_pu, p_pd, ext_en = '0, ext_val = '0;
   int bad_count = 0, checked = 0;
   always #5 mclk = ~mclk;
   ppm_pin_mux dut (.mclk(mclk), .srst(srst), .ext_reset_n(ext_reset_n), .select_strap1(s1),
      .select_strap2(s2), .spare_select_strap(s3), .hub_attached(hub_attached),
      .wr_valid(wr_valid), .wr_src(wr_src), .wr_pin(wr_pin), .wr_func(wr_func), .wr_accept(wr_accept),
      .wr_reject(wr_reject), .port_enable(port_enable), .fn_out(fo), .fn_in(fn_in),
      .cfg3_active(cfg3_active), .strap_reserved(strap_reserved), .spare_strap_ok(spare_strap_ok),
      .prog_function_pins_in(p_in), .prog_function_pins_out(p_out), .prog_function_pins_oe_n(p_oe_n),
      .prog_function_pins_pu(p_pu), .prog_function_pins_pd(p_pd));
   ppm_board board (.pad_oe_n(p_oe_n), .pad_out(p_out), .pad_pu(p_pu), .pad_pd(p_pd),
      .ext_en(ext_en), .ext_val(ext_val), .pin_lvl(p_in));
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic pad(input int p, input logic [3:0] exp);
      cmp({4'h0, p_oe_n[p], p_oe_n[p] ? 1'b0 : p_out[p], p_pu[p], p_pd[p]}, {4'h0, exp});
   endtask
   // Back to back: the caller drops wr_valid after the last write
   task automatic wr(input ppm_pkg::ppm_src_t s, input logic [4:0] p, input ppm_pkg::ppm_func_t f,
                     input logic acc);
      wr_valid = 1'b1;
      wr_src = s;
      wr_pin = p;
      wr_func = f;
      #1 cmp({6'h00, wr_accept, wr_reject}, {6'h00, acc, ~acc});
      @(negedge mclk);
   endtask
   task automatic tally_and_finish;
      if (bad_count == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #200000;
      bad_count++;
      tally_and_finish();
   end
   initial begin
      fo.bridge_clk_oe_n = 1'b0;
      fo.bridge_dat_oe_n = 1'b0;
      fo.target_clk_oe_n = 1'b0;
      fo.target_dat_oe_n = 1'b0;
      fo.flash_io_oe_n = 4'h0;
      step(12);
      srst = 1'b0;
      step(4);
      cmp({cfg3_active, strap_reserved, spare_strap_ok}, 8'h05);
      for (int p = 3; p <= 31; p++) pad(p, exp_map[(p-3)*4 +: 4]);
      port_enable = 6'h3F;
      ext_en[3] = 1'b1;
      ext_en[19] = 1'b1;
      ext_en[30] = 1'b1;
      ext_en[17] = 1'b1;
      ext_val = '1;
      step(3);
      pad(17, 4'hA);
      cmp({fn_in.audio_data_in, fn_in.microphone_present, fn_in.upstream_bus_power}, 8'h07);
      cmp({7'h00, fn_in.port_overcurrent_n[0]}, 8'h01);
      ext_val = '0;
      step(2);
      cmp({fn_in.audio_data_in, fn_in.microphone_present, fn_in.upstream_bus_power}, 8'h00);
      cmp({7'h00, fn_in.port_overcurrent_n[0]}, 8'h00);
      wr(ppm_pkg::SRC_TWOWIRE_CFG, 5'h08, ppm_pkg::FN_AUDIO_WS, 1'b1);
      wr(ppm_pkg::SRC_OTP, 5'h09, ppm_pkg::FN_AUDIO_SCK, 1'b1);
      wr(ppm_pkg::SRC_USB_RUN, 5'h1D, ppm_pkg::FN_AUDIO_MCLK, 1'b0);
      wr(ppm_pkg::SRC_TWOWIRE_CFG, 5'h02, ppm_pkg::FN_AUDIO_WS, 1'b0);
      wr_valid = 1'b0;
      step(2);
      pad(8, 4'h4);
      pad(9, 4'h4);
      pad(29, 4'h9);
      hub_attached = 1'b1;
      wr(ppm_pkg::SRC_USB_RUN, 5'h1D, ppm_pkg::FN_AUDIO_MCLK, 1'b1);
      wr(ppm_pkg::SRC_TWOWIRE_RUN, 5'h08, ppm_pkg::FN_NONE, 1'b1);
      wr(ppm_pkg::SRC_OTP, 5'h09, ppm_pkg::FN_NONE, 1'b0);
      wr_valid = 1'b0;
      step(2);
      pad(29, 4'h4);
      pad(8, 4'h9);
      pad(9, 4'h4);
      pad(7, 4'h4);
      ext_reset_n = 1'b0;
      s1 = ppm_pkg::LVL_PU_10K;
      s3 = ppm_pkg::LVL_PU_200K;
      step(2);
      ext_reset_n = 1'b1;
      wr(ppm_pkg::SRC_TWOWIRE_RUN, 5'h09, ppm_pkg::FN_AUDIO_WS, 1'b0);
      wr_valid = 1'b0;
      step(3);
      cmp({cfg3_active, strap_reserved, spare_strap_ok}, 8'h02);
      pad(4, 4'h9);
      s1 = ppm_pkg::LVL_PD_10K;
      s3 = ppm_pkg::LVL_PD_200K;
      srst = 1'b1;
      step(2);
      srst = 1'b0;
      step(3);
      cmp({cfg3_active, strap_reserved, spare_strap_ok}, 8'h05);
      pad(9, 4'h9);
      pad(29, 4'h9);
      tally_and_finish();
   end
endmodule
